// file: rtl/tcrb_pkg.sv
/*
 * tcrb_pkg: constants shared by the capture/reload/baud timer.
 * assumes an 8-bit special function register bus with 8-bit addresses.
 */
package tcrb_pkg;
    localparam logic [7:0] TCRB_ADDR_CTRL   = 8'hc9;
    localparam logic [7:0] TCRB_ADDR_RCAP_L = 8'he4;
    localparam logic [7:0] TCRB_ADDR_RCAP_H = 8'he5;
    // count byte addresses are not fixed by the map; chosen here
    localparam logic [7:0] TCRB_ADDR_CNT_L  = 8'he6;
    localparam logic [7:0] TCRB_ADDR_CNT_H  = 8'he7;

    localparam int TCRB_BIT_OVF   = 7;
    localparam int TCRB_BIT_EXF   = 6;
    localparam int TCRB_BIT_RXSEL = 5;
    localparam int TCRB_BIT_TXSEL = 4;
    localparam int TCRB_BIT_EXEN  = 3;
    localparam int TCRB_BIT_RUN   = 2;
    localparam int TCRB_BIT_CSRC  = 1;
    localparam int TCRB_BIT_CAPRL = 0;

    localparam logic [7:0]  TCRB_CTRL_RESET = 8'h00;
    localparam logic [7:0]  TCRB_BYTE_RESET = 8'h00;
    localparam logic [15:0] TCRB_CNT_MAX    = 16'hffff;
    localparam logic [15:0] TCRB_CNT_ONE    = 16'h0001;

    // prescale divisors of the system clock
    localparam logic [3:0] TCRB_DIV_SLOW = 4'hb; // divide by 12, count-1
    localparam logic [3:0] TCRB_DIV_BAUD = 4'h1; // divide by 2, count-1
    localparam logic [3:0] TCRB_DIV_ZERO = 4'h0;

    typedef enum logic [1:0] {
        TCRB_MODE_CAPTURE,
        TCRB_MODE_RELOAD,
        TCRB_MODE_BAUD
    } tcrb_mode_t;
endpackage

// file: rtl/tcrb_timer.sv
/*
 * tcrb_timer: 16-bit counter/timer with capture, auto-reload and
 * baud tick generation for the second serial port.
 * also holds the pin falling-edge detector that the timer uses twice.
 * assumes a byte-wide register bus in the clock domain, single-cycle
 * write and read strobes, and asynchronous count and trigger pins.
 */
// Overview of operation
// - baud mode reloads counter from pair on overflow
// - baud mode: no overflow flag, tick instead
// - either baud select bit forces baud reload mode
// - baud timer function counts at clock/2
// - external count: rate = fin/(16*(65536-reload))
// - baud mode trigger edge sets flag, no reload
// - overflow flag set by hardware, software clears
// - trigger edge capture/reload sets external flag
// - rx select picks this timer for rx clock
// - tx select picks this timer for tx clock
// - trigger enable gates capture or reload edges
// - run bit starts and stops counting
// - source bit: prescaled clock or count pin
// - capture/reload bit chooses operation
// - pair captures count or holds reload value
// - count bytes readable and writable
// - counts up, overflow at ffff goes to 0000 in capture mode, else to the pair
// - capture copies count, sets flag, interrupts
`timescale 1ns/1ps
module tcrb_timer (
    input  wire logic                  clock,
    input  wire logic                  rst_b,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [7:0]                 reg_rdata,
    input  wire logic                  prescale_select,
    input  wire logic                  external_count_pin,
    input  wire logic                  external_trigger_pin,
    input  wire logic                  other_timer_ovf,
    output logic                       irq,
    output logic                       rx_shift_tick,
    output logic                       tx_shift_tick,
    output logic                       baud_ovf_tick
);
    import tcrb_pkg::*;

    logic [7:0]  ctrl_ff;
    logic [7:0]  rcap_l_ff;
    logic [7:0]  rcap_h_ff;
    logic [15:0] cnt_ff;
    logic [3:0]  pre_ff;
    logic [7:0]  reg_rdata_ff;
    logic        irq_ff;
    logic        rx_tick_ff;
    logic        tx_tick_ff;
    logic        baud_tick_ff;

    logic        baud_mode;
    logic        run;
    tcrb_mode_t  mode;
    logic [3:0]  pre_limit;
    logic        pre_tick;
    logic        cnt_edge;
    logic        trg_edge;
    logic        inc;
    logic        ovf;
    logic        ext_act;
    logic        do_capture;
    logic        do_reload;
    logic        wr_ctrl;
    logic        wr_rcap_l;
    logic        wr_rcap_h;
    logic        wr_cnt_l;
    logic        wr_cnt_h;
    logic        set_ovf;
    logic        set_exf;
    logic        own_tick;
    logic [7:0]  nxt_ctrl;
    logic [15:0] nxt_cnt;
    logic [7:0]  nxt_rdata;

    // pins: two stages to settle, a third for the edge history
    tcrb_fall_det cnt_fall_u (
        .clock (clock),
        .rst_b (rst_b),
        .pin   (external_count_pin),
        .fall  (cnt_edge)
    );
    tcrb_fall_det trg_fall_u (
        .clock (clock),
        .rst_b (rst_b),
        .pin   (external_trigger_pin),
        .fall  (trg_edge)
    );

    assign baud_mode = ctrl_ff[TCRB_BIT_RXSEL] | ctrl_ff[TCRB_BIT_TXSEL];
    assign run       = ctrl_ff[TCRB_BIT_RUN];

    always_comb begin
        if (baud_mode) begin
            mode = TCRB_MODE_BAUD;
        end else if (ctrl_ff[TCRB_BIT_CAPRL]) begin
            mode = TCRB_MODE_CAPTURE;
        end else begin
            mode = TCRB_MODE_RELOAD;
        end
    end

    // prescaler: baud mode ignores the prescale select
    always_comb begin
        if (baud_mode) begin
            pre_limit = TCRB_DIV_BAUD;
        end else if (prescale_select) begin
            pre_limit = TCRB_DIV_ZERO;
        end else begin
            pre_limit = TCRB_DIV_SLOW;
        end
    end
    assign pre_tick = (pre_ff >= pre_limit);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pre_ff <= TCRB_DIV_ZERO;
        end else if (!run || pre_tick) begin
            pre_ff <= TCRB_DIV_ZERO;
        end else begin
            pre_ff <= pre_ff + 4'h1;
        end
    end

    // source select: count pin edges or prescaled clock
    assign inc = run && (ctrl_ff[TCRB_BIT_CSRC] ? cnt_edge
                                                : pre_tick);
    assign ovf = inc && (cnt_ff == TCRB_CNT_MAX);

    assign ext_act    = trg_edge && ctrl_ff[TCRB_BIT_EXEN];
    assign do_capture = ext_act && (mode == TCRB_MODE_CAPTURE);
    // baud mode never reloads from the trigger pin
    assign do_reload  = ovf && (mode != TCRB_MODE_CAPTURE)
                     || ext_act && (mode == TCRB_MODE_RELOAD);

    assign wr_ctrl   = reg_wr && (reg_addr == TCRB_ADDR_CTRL);
    assign wr_rcap_l = reg_wr && (reg_addr == TCRB_ADDR_RCAP_L);
    assign wr_rcap_h = reg_wr && (reg_addr == TCRB_ADDR_RCAP_H);
    assign wr_cnt_l  = reg_wr && (reg_addr == TCRB_ADDR_CNT_L);
    assign wr_cnt_h  = reg_wr && (reg_addr == TCRB_ADDR_CNT_H);
    assign set_ovf   = ovf && !baud_mode;
    assign set_exf   = ext_act;
    assign own_tick  = ovf && baud_mode;

    // count byte addresses are free choices; refuse any that collide
    if (TCRB_ADDR_CNT_L == TCRB_ADDR_CNT_H ||
        TCRB_ADDR_CNT_L == TCRB_ADDR_CTRL ||
        TCRB_ADDR_CNT_H == TCRB_ADDR_CTRL ||
        TCRB_ADDR_CNT_L == TCRB_ADDR_RCAP_L ||
        TCRB_ADDR_CNT_H == TCRB_ADDR_RCAP_L ||
        TCRB_ADDR_CNT_L == TCRB_ADDR_RCAP_H ||
        TCRB_ADDR_CNT_H == TCRB_ADDR_RCAP_H) begin : g_addr_clash
        $error("tcrb_timer: a count byte address overlaps a register");
    end

    // set wins over a simultaneous software clear
    always_comb begin
        nxt_ctrl = wr_ctrl ? reg_wdata : ctrl_ff;
        if (set_ovf) begin
            nxt_ctrl[TCRB_BIT_OVF] = 1'b1;
        end
        if (set_exf) begin
            nxt_ctrl[TCRB_BIT_EXF] = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ctrl_ff <= TCRB_CTRL_RESET;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // reload/capture pair; hardware capture beats a software write
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rcap_l_ff <= TCRB_BYTE_RESET;
            rcap_h_ff <= TCRB_BYTE_RESET;
        end else if (do_capture) begin
            rcap_l_ff <= cnt_ff[7:0];
            rcap_h_ff <= cnt_ff[15:8];
        end else begin
            if (wr_rcap_l) begin
                rcap_l_ff <= reg_wdata;
            end
            if (wr_rcap_h) begin
                rcap_h_ff <= reg_wdata;
            end
        end
    end

    // counter: reload beats increment, software write beats both
    always_comb begin
        nxt_cnt = cnt_ff;
        if (do_reload) begin
            nxt_cnt = {rcap_h_ff, rcap_l_ff};
        end else if (inc) begin
            nxt_cnt = cnt_ff + TCRB_CNT_ONE;
        end
        if (wr_cnt_l) begin
            nxt_cnt[7:0] = reg_wdata;
        end
        if (wr_cnt_h) begin
            nxt_cnt[15:8] = reg_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cnt_ff <= {TCRB_BYTE_RESET, TCRB_BYTE_RESET};
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    always_comb begin
        case (reg_addr)
            TCRB_ADDR_CTRL:   nxt_rdata = ctrl_ff;
            TCRB_ADDR_RCAP_L: nxt_rdata = rcap_l_ff;
            TCRB_ADDR_RCAP_H: nxt_rdata = rcap_h_ff;
            TCRB_ADDR_CNT_L:  nxt_rdata = cnt_ff[7:0];
            TCRB_ADDR_CNT_H:  nxt_rdata = cnt_ff[15:8];
            default:          nxt_rdata = TCRB_BYTE_RESET;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            reg_rdata_ff <= TCRB_BYTE_RESET;
        end else if (reg_rd) begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

    // serial port divides the tick by sixteen itself
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            baud_tick_ff <= 1'b0;
            rx_tick_ff   <= 1'b0;
            tx_tick_ff   <= 1'b0;
        end else begin
            baud_tick_ff <= own_tick;
            rx_tick_ff   <= ctrl_ff[TCRB_BIT_RXSEL]
                          ? own_tick : other_timer_ovf;
            tx_tick_ff   <= ctrl_ff[TCRB_BIT_TXSEL]
                          ? own_tick : other_timer_ovf;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_ctrl[TCRB_BIT_OVF]
                    | nxt_ctrl[TCRB_BIT_EXF];
        end
    end

    assign reg_rdata     = reg_rdata_ff;
    assign irq           = irq_ff;
    assign rx_shift_tick = rx_tick_ff;
    assign tx_shift_tick = tx_tick_ff;
    assign baud_ovf_tick = baud_tick_ff;
endmodule

// falling-edge detector behind a synchroniser for one asynchronous pin
module tcrb_fall_det #(
    parameter int STAGES = 2
) (
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic pin,
    output logic      fall
);

    // one stage beyond the synchroniser keeps the edge history
    localparam int DEPTH = STAGES + 1;

    logic [DEPTH-1:0] pin_ff;

    // fewer than two stages would let a metastable level reach logic
    if (STAGES < 2) begin : g_bad_depth
        $error("tcrb_fall_det needs at least two synchroniser stages");
    end

    // reset to the pin's idle level so that no false edge follows reset
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pin_ff <= '1;
        end else begin
            pin_ff <= {pin_ff[DEPTH-2:0], pin};
        end
    end

    // only the last two stages are compared, never the first
    assign fall = pin_ff[DEPTH-1] & ~pin_ff[DEPTH-2];
endmodule

// file: tb/tcrb_far_model.sv
/* tcrb_far_model: stand-in for the other timer feeding the port.
   assumes the timer's clock; pulses land 1 ns after the edge. */
`timescale 1ns/1ps
module tcrb_far_model #(
    parameter int PERIOD = 5
) (
    input  wire logic clock,
    output logic      other_timer_ovf
);
    int   div = 0;
    logic pulse_ff = 1'b0;
    assign other_timer_ovf = pulse_ff;
    always @(posedge clock) begin
        div = (div + 1) % PERIOD;
        pulse_ff <= #1 (div == 0);
    end
endmodule

// file: tb/tcrb_timer_chk.sv
/* tcrb_timer_chk: port assertions for tcrb_timer, bound below.
   assumes one clock domain and the byte register map of tcrb_pkg. */
`timescale 1ns/1ps
module tcrb_timer_chk (
    input wire logic       clock,
    input wire logic       rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       other_timer_ovf,
    input wire logic       irq,
    input wire logic       rx_shift_tick,
    input wire logic       tx_shift_tick,
    input wire logic       baud_ovf_tick
);
    import tcrb_pkg::*;
    logic sel_rx_ff, sel_tx_ff;
    wire logic bsel = sel_rx_ff | sel_tx_ff;
    wire logic ctrl_wr = reg_wr && reg_addr == TCRB_ADDR_CTRL;
    wire logic mapped = reg_addr inside {TCRB_ADDR_CTRL, TCRB_ADDR_RCAP_L,
        TCRB_ADDR_RCAP_H, TCRB_ADDR_CNT_L, TCRB_ADDR_CNT_H};
    // shadow of the select bits, same timing as the design's own copy
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sel_rx_ff <= 1'b0;
            sel_tx_ff <= 1'b0;
        end else if (ctrl_wr) begin
            sel_rx_ff <= reg_wdata[TCRB_BIT_RXSEL];
            sel_tx_ff <= reg_wdata[TCRB_BIT_TXSEL];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_one_tick;
        baud_ovf_tick ##1 !baud_ovf_tick;
    endsequence
    AST_RST_QUIET: assert property (
        $rose(rst_b) |-> !irq && !baud_ovf_tick)
        else $error("output active at reset release");
    AST_UNMAPPED_RD: assert property (
        reg_rd && !mapped |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_RDATA_HOLD: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    AST_IRQ_CLEAR: assert property (
        $fell(irq) |-> $past(ctrl_wr))
        else $error("irq dropped without software clear");
    AST_TICK_SPACE: assert property (
        baud_ovf_tick |-> s_one_tick)
        else $error("baud ticks on adjacent cycles");
    AST_RX_OTHER: assert property (
        !sel_rx_ff |=> rx_shift_tick == $past(other_timer_ovf))
        else $error("rx tick not from other timer");
    AST_TX_OTHER: assert property (
        !sel_tx_ff |=> tx_shift_tick == $past(other_timer_ovf))
        else $error("tx tick not from other timer");
    AST_RX_OWN: assert property (
        sel_rx_ff |=> rx_shift_tick == baud_ovf_tick)
        else $error("rx tick not from this timer");
    AST_TX_OWN: assert property (
        sel_tx_ff |=> tx_shift_tick == baud_ovf_tick)
        else $error("tx tick not from this timer");
    AST_BAUD_ONLY: assert property (
        !bsel && !$past(bsel) && !$past(bsel, 2) |-> !baud_ovf_tick)
        else $error("baud tick outside baud mode");
endmodule

bind tcrb_timer tcrb_timer_chk chk_u (.clock(clock), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .other_timer_ovf(other_timer_ovf), .rx_shift_tick(rx_shift_tick),
    .tx_shift_tick(tx_shift_tick), .baud_ovf_tick(baud_ovf_tick));

// file: tb/tcrb_timer_tb.sv
/* tcrb_timer_tb: self-checking bench for tcrb_timer.
   assumes the far model drives other_timer_ovf; reads checked by queue. */
`timescale 1ns/1ps
module tcrb_timer_tb;
    import tcrb_pkg::*;
    logic        clock, rst_b, reg_wr, reg_rd, psel, cpin, tpin, oovf;
    logic        irq, rxt, txt, bt;
    logic        rd_q = 1'b0;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, c;
    logic [7:0]  exp_q[$];
    logic [31:0] seed = 32'h7cfde432;
    int          n_mismatch = 0, cmp_count = 0, i, gap, m;
    tcrb_timer dut_u (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .prescale_select(psel),
        .external_count_pin(cpin), .external_trigger_pin(tpin),
        .other_timer_ovf(oovf), .irq(irq), .rx_shift_tick(rxt),
        .tx_shift_tick(txt), .baud_ovf_tick(bt));
    tcrb_far_model far_u (.clock(clock), .other_timer_ovf(oovf));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic complete_run();
        $display("counts: %0d compares, %0d mismatches",
                 cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, s);
        cmp_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic tmo(input int n, input int lim);
        if (n >= lim) begin
            n_mismatch++;
            complete_run();
        end
    endtask
    task automatic step();
        @(posedge clock);
        #1;
    endtask
    // strobes drop and a full cycle passes, so calls can follow directly
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        step();
        reg_wr = 1'b0;
        step();
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        exp_q.push_back(e);
        step();
        reg_rd = 1'b0;
        step();
    endtask
    // held low long enough to pass the pin synchroniser
    task automatic fall(input bit trig);
        if (trig) tpin = 1'b0;
        else cpin = 1'b0;
        repeat (6) step();
        tpin = 1'b1;
        cpin = 1'b1;
        repeat (6) step();
    endtask
    always @(posedge clock) begin
        if (rd_q) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
        rd_q <= reg_rd;
    end
    initial begin
        rst_b = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        psel = 1'b1;
        cpin = 1'b1;
        tpin = 1'b1;
        repeat (4) @(posedge clock);
        #1 rst_b = 1'b1;
        repeat (3) step();
        rd(TCRB_ADDR_CTRL, 8'h00);
        rd(TCRB_ADDR_RCAP_L, 8'h00);
        rd(TCRB_ADDR_RCAP_H, 8'h00);
        rd(8'h55, 8'h00);
        seed = xs(seed);
        wr(TCRB_ADDR_CNT_L, seed[7:0]);
        wr(TCRB_ADDR_CNT_H, seed[15:8]);
        rd(TCRB_ADDR_CNT_L, seed[7:0]);
        rd(TCRB_ADDR_CNT_H, seed[15:8]);
        $display("test registers done");
        wr(TCRB_ADDR_RCAP_H, seed[23:16]);
        wr(TCRB_ADDR_RCAP_L, 8'h00);
        wr(TCRB_ADDR_CNT_H, 8'hff);
        wr(TCRB_ADDR_CNT_L, 8'hf0);
        wr(TCRB_ADDR_CTRL, 8'h04);
        for (i = 0; i < 60 && irq !== 1'b1; i++) step();
        tmo(i, 60);
        wr(TCRB_ADDR_CTRL, 8'h80);
        rd(TCRB_ADDR_CTRL, 8'h80);
        rd(TCRB_ADDR_CNT_H, seed[23:16]);
        wr(TCRB_ADDR_CTRL, 8'h00);
        step();
        chk("irq", 1'b0, irq);
        wr(TCRB_ADDR_CNT_L, 8'h33);
        repeat (10) step();
        rd(TCRB_ADDR_CNT_L, 8'h33);
        $display("test overflow done");
        wr(TCRB_ADDR_CTRL, 8'h01);
        fall(1'b1);
        rd(TCRB_ADDR_CTRL, 8'h01);
        seed = xs(seed);
        wr(TCRB_ADDR_CNT_L, seed[7:0]);
        wr(TCRB_ADDR_CNT_H, seed[15:8]);
        wr(TCRB_ADDR_CTRL, 8'h09);
        fall(1'b1);
        chk("irq", 1'b1, irq);
        rd(TCRB_ADDR_RCAP_L, seed[7:0]);
        rd(TCRB_ADDR_RCAP_H, seed[15:8]);
        rd(TCRB_ADDR_CTRL, 8'h49);
        wr(TCRB_ADDR_CNT_L, 8'h00);
        wr(TCRB_ADDR_CTRL, 8'h08);
        fall(1'b1);
        rd(TCRB_ADDR_CNT_L, seed[7:0]);
        wr(TCRB_ADDR_CNT_L, 8'h10);
        wr(TCRB_ADDR_CTRL, 8'h06);
        repeat (3) fall(1'b0);
        wr(TCRB_ADDR_CTRL, 8'h00);
        rd(TCRB_ADDR_CNT_L, 8'h13);
        $display("test trigger and count pins done");
        // prescale at /12 must not matter in baud mode
        psel = 1'b0;
        wr(TCRB_ADDR_RCAP_H, 8'hff);
        wr(TCRB_ADDR_RCAP_L, 8'hf0);
        // start near the top so the first tick comes within the bound
        wr(TCRB_ADDR_CNT_H, 8'hff);
        wr(TCRB_ADDR_CNT_L, 8'hf0);
        for (m = 0; m < 2; m++) begin
            c = m ? 8'h15 : 8'h25;
            wr(TCRB_ADDR_CTRL, c);
            for (i = 0; i < 200 && bt !== 1'b1; i++) step();
            tmo(i, 200);
            chk("own tick", 1'b1, m ? txt : rxt);
            step();
            for (gap = 1; gap < 100 && bt !== 1'b1; gap++) step();
            tmo(gap, 100);
            chk("tick gap", 16'd32, gap[15:0]);
            chk("irq", 1'b0, irq);
            rd(TCRB_ADDR_CTRL, c);
        end
        wr(TCRB_ADDR_CTRL, 8'h2d);
        fall(1'b1);
        chk("irq", 1'b1, irq);
        rd(TCRB_ADDR_CTRL, 8'h6d);
        wr(TCRB_ADDR_CTRL, 8'h00);
        repeat (3) step();
        $display("test baud done");
        complete_run();
    end
endmodule
